/* File: core/hdse_map.vh */
`ifndef HDSE_MAP_VH
`define HDSE_MAP_VH

// =====================================
// Register indices (byte address = 4 x index)
`define HDSE_IDX_LC_PORT 8'hD0
`define HDSE_IDX_LT_PORT 8'hD1
`define HDSE_IDX_LP_PORT 8'hD2
`define HDSE_IDX_VAL_PORT 8'hD3
`define HDSE_IDX_TRIG_LINE 8'hD4
`define HDSE_IDX_TRIG_DUR 8'hD6
`define HDSE_IDX_HPHASE 8'hD8
`define HDSE_IDX_VPHASE 8'hDA
`define HDSE_IDX_CTRL 8'hDC
`define HDSE_IDX_STATUS 8'hE0

// =====================================
// Port write fields
`define HDSE_START_BIT 8

// =====================================
// Array sizes in bytes
`define HDSE_LC_BYTES 8'h1E
`define HDSE_LT_BYTES 8'h3C
`define HDSE_LP_BYTES 8'h38
`define HDSE_VAL_BYTES 8'h10

// =====================================
// Level offset and entry limits
`define HDSE_LEVEL_OFS 9'h034
`define HDSE_LAST_ENTRY 4'hE

`endif

/* File: core/hdse_engine.v */
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "hdse_map.vh"
module hdse_engine (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Avalon-MM slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Timing references from pins
    input wire hsync_ref,
    input wire vsync_ref,
    // HD data path
    input wire [9:0] hd_g_in,
    input wire [9:0] hd_b_in,
    input wire [9:0] hd_r_in,
    output reg [9:0] hd_g_out,
    output reg [9:0] hd_b_out,
    output reg [9:0] hd_r_out,
    // Sync pins
    output reg composite_hsync_pin,
    output reg vertical_sync_pin
);

// =====================================
// Storage
reg [7:0] lc_mem [0:29];
reg [7:0] lt_mem [0:59];
reg [7:0] lp_mem [0:55];
reg [7:0] val_mem [0:15];
reg [7:0] lc_wp_r, lt_wp_r, lp_wp_r, val_wp_r;

// =====================================
// Registers
reg [15:0] trig_line_r, trig_dur_r, hphase_r, vphase_r;
reg sync_engine_enable_r;
reg ack_r;

// =====================================
// Engine state
reg run_r;
reg [3:0] entry_r;
reg [9:0] lc_cnt_r;
reg [2:0] event_r;
reg [1:0] pair_r;
reg [9:0] dur_cnt_r;
reg fresh_r;
reg ld_lc_r;

// =====================================
// Pin synchronisers and position counters
reg [15:0] pix_cnt_r, line_cnt_r;

wire wr_go = avs_write & ack_r;
wire [7:0] wbyte = avs_writedata[7:0];
wire wstart = avs_writedata[`HDSE_START_BIT];

assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

// =====================================
// Array decode
wire [7:0] lc_lo = lc_mem[{entry_r, 1'b0}];
wire [7:0] lc_hi = lc_mem[{entry_r, 1'b1}];
wire [9:0] rep_cnt = {lc_hi[1:0], lc_lo};
wire [3:0] ltype = lc_hi[7:4];
wire ltype_ok = (ltype != 4'h0) && (rep_cnt != 10'h000);
wire [3:0] lt_idx = ltype - 4'h1;
wire [7:0] lt_byte = lt_mem[{lt_idx, event_r[2:1]}];
wire [2:0] pat = event_r[0] ? lt_byte[6:4] : lt_byte[2:0];
wire pat_ok = (pat != 3'h0);
wire [2:0] pat_idx = pat - 3'h1;
wire [7:0] lp_lo = lp_mem[{pat_idx, pair_r, 1'b0}];
wire [7:0] lp_hi = lp_mem[{pat_idx, pair_r, 1'b1}];
wire [9:0] dur = {lp_hi[1:0], lp_lo};
wire [3:0] vptr = lp_hi[7:4];
wire pair_ok = ltype_ok && pat_ok && (dur != 10'h000);
wire [7:0] lvl_byte = val_mem[{vptr[2:0], 1'b0}];
wire [7:0] sync_byte = val_mem[{vptr[2:0], 1'b1}];
wire [8:0] level = {lvl_byte[7], lvl_byte} + `HDSE_LEVEL_OFS;
wire insert = run_r && pair_ok;
wire pair_done = ~pair_ok | (~fresh_r && dur_cnt_r == 10'h000);
wire line_done = pair_done && pair_r == 2'h3 && event_r == 3'h7;

// =====================================
// Trigger
wire trig = sync_engine_enable_r && pix_cnt_r == hphase_r && line_cnt_r == vphase_r;
wire hs_edge;
wire vs_edge;

hdse_pin_filt u_hs_filt (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(hsync_ref),
    .rise(hs_edge)
);

hdse_pin_filt u_vs_filt (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(vsync_ref),
    .rise(vs_edge)
);

// =====================================
// Channel adders
wire [9:0] g_sum;
wire [9:0] b_sum;
wire [9:0] r_sum;

hdse_sat_add #(
    .W(10)
) u_add_g (
    .chan(hd_g_in),
    .lvl(level),
    .sum_sat(g_sum)
);

hdse_sat_add #(
    .W(10)
) u_add_b (
    .chan(hd_b_in),
    .lvl(level),
    .sum_sat(b_sum)
);

hdse_sat_add #(
    .W(10)
) u_add_r (
    .chan(hd_r_in),
    .lvl(level),
    .sum_sat(r_sum)
);

// =====================================
// Bus slave
always @(posedge sys_clk) begin
    if (rst) begin
        ack_r <= 1'b0;
        avs_readdata <= 32'h0000_0000;
    end else begin
        ack_r <= (avs_read | avs_write) & ~ack_r;
        if (avs_read & ~ack_r) begin
            case (avs_address)
                `HDSE_IDX_TRIG_LINE: avs_readdata <= {16'h0000, trig_line_r};
                `HDSE_IDX_TRIG_DUR: avs_readdata <= {16'h0000, trig_dur_r};
                `HDSE_IDX_HPHASE: avs_readdata <= {16'h0000, hphase_r};
                `HDSE_IDX_VPHASE: avs_readdata <= {16'h0000, vphase_r};
                `HDSE_IDX_CTRL: avs_readdata <= {31'h0000_0000, sync_engine_enable_r};
                `HDSE_IDX_STATUS: avs_readdata <= {12'h000, run_r, pair_r, event_r,
                    entry_r, lc_cnt_r};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        trig_line_r <= 16'h0000;
        trig_dur_r <= 16'h0000;
        hphase_r <= 16'h0000;
        vphase_r <= 16'h0000;
        sync_engine_enable_r <= 1'b0;
    end else if (wr_go) begin
        case (avs_address)
            `HDSE_IDX_TRIG_LINE: trig_line_r <= avs_writedata[15:0];
            `HDSE_IDX_TRIG_DUR: trig_dur_r <= avs_writedata[15:0];
            `HDSE_IDX_HPHASE: hphase_r <= avs_writedata[15:0];
            `HDSE_IDX_VPHASE: vphase_r <= avs_writedata[15:0];
            `HDSE_IDX_CTRL: sync_engine_enable_r <= avs_writedata[0];
            default: ;
        endcase
    end
end

// =====================================
// Array ports: start byte sets pointer, data bytes auto-increment
always @(posedge sys_clk) begin
    if (rst) begin
        lc_wp_r <= 8'h00;
        lt_wp_r <= 8'h00;
        lp_wp_r <= 8'h00;
        val_wp_r <= 8'h00;
    end else if (wr_go) begin
        case (avs_address)
            `HDSE_IDX_LC_PORT: begin
                if (wstart)
                    lc_wp_r <= wbyte;
                else if (lc_wp_r < `HDSE_LC_BYTES) begin
                    lc_mem[lc_wp_r[4:0]] <= wbyte;
                    lc_wp_r <= lc_wp_r + 8'h01;
                end
            end
            `HDSE_IDX_LT_PORT: begin
                if (wstart)
                    lt_wp_r <= wbyte;
                else if (lt_wp_r < `HDSE_LT_BYTES) begin
                    lt_mem[lt_wp_r[5:0]] <= wbyte;
                    lt_wp_r <= lt_wp_r + 8'h01;
                end
            end
            `HDSE_IDX_LP_PORT: begin
                if (wstart)
                    lp_wp_r <= wbyte;
                else if (lp_wp_r < `HDSE_LP_BYTES) begin
                    lp_mem[lp_wp_r[5:0]] <= wbyte;
                    lp_wp_r <= lp_wp_r + 8'h01;
                end
            end
            `HDSE_IDX_VAL_PORT: begin
                if (wstart)
                    val_wp_r <= wbyte;
                else if (val_wp_r < `HDSE_VAL_BYTES) begin
                    val_mem[val_wp_r[3:0]] <= wbyte;
                    val_wp_r <= val_wp_r + 8'h01;
                end
            end
            default: ;
        endcase
    end
end

// =====================================
// Reference pins and position counters
always @(posedge sys_clk) begin
    if (rst) begin
        pix_cnt_r <= 16'h0000;
        line_cnt_r <= 16'h0000;
    end else begin
        if (hs_edge)
            pix_cnt_r <= 16'h0000;
        else
            pix_cnt_r <= pix_cnt_r + 16'h0001;
        if (vs_edge)
            line_cnt_r <= 16'h0000;
        else if (hs_edge)
            line_cnt_r <= line_cnt_r + 16'h0001;
    end
end

// =====================================
// Sequencer
always @(posedge sys_clk) begin
    if (rst) begin
        run_r <= 1'b0;
        entry_r <= 4'h0;
        lc_cnt_r <= 10'h000;
        event_r <= 3'h0;
        pair_r <= 2'h0;
        dur_cnt_r <= 10'h000;
        fresh_r <= 1'b0;
        ld_lc_r <= 1'b0;
    end else if (!sync_engine_enable_r) begin
        run_r <= 1'b0;
    end else if (trig) begin
        run_r <= 1'b1;
        lc_cnt_r <= trig_line_r[9:0];
        entry_r <= trig_line_r[13:10];
        pair_r <= trig_line_r[15:14];
        dur_cnt_r <= trig_dur_r[9:0];
        event_r <= trig_dur_r[12:10];
        fresh_r <= 1'b0;
        ld_lc_r <= 1'b0;
    end else if (run_r) begin
        if (ld_lc_r) begin
            lc_cnt_r <= rep_cnt - 10'h001;
            ld_lc_r <= 1'b0;
        end
        if (!ltype_ok) begin
            entry_r <= (entry_r >= `HDSE_LAST_ENTRY) ? 4'h0 : entry_r + 4'h1;
            event_r <= 3'h0;
            pair_r <= 2'h0;
            fresh_r <= 1'b1;
            ld_lc_r <= 1'b1;
        end else if (pair_done) begin
            fresh_r <= 1'b1;
            pair_r <= pair_r + 2'h1;
            if (pair_r == 2'h3)
                event_r <= event_r + 3'h1;
            if (line_done) begin
                if (lc_cnt_r == 10'h000 && !ld_lc_r) begin
                    entry_r <= (entry_r >= `HDSE_LAST_ENTRY) ? 4'h0 : entry_r + 4'h1;
                    ld_lc_r <= 1'b1;
                end else if (!ld_lc_r) begin
                    lc_cnt_r <= lc_cnt_r - 10'h001;
                end
            end
        end else begin
            fresh_r <= 1'b0;
            if (fresh_r)
                dur_cnt_r <= dur - 10'h001;
            else
                dur_cnt_r <= dur_cnt_r - 10'h001;
        end
    end
end

// =====================================
// Level insertion and sync pins
always @(posedge sys_clk) begin
    if (rst) begin
        hd_g_out <= 10'h000;
        hd_b_out <= 10'h000;
        hd_r_out <= 10'h000;
        composite_hsync_pin <= 1'b0;
        vertical_sync_pin <= 1'b0;
    end else begin
        if (insert) begin
            hd_g_out <= g_sum;
            hd_b_out <= vptr[3] ? hd_b_in : b_sum;
            hd_r_out <= vptr[3] ? hd_r_in : r_sum;
            composite_hsync_pin <= sync_byte[0];
            vertical_sync_pin <= sync_byte[1];
        end else begin
            hd_g_out <= hd_g_in;
            hd_b_out <= hd_b_in;
            hd_r_out <= hd_r_in;
            if (!run_r) begin
                composite_hsync_pin <= 1'b0;
                vertical_sync_pin <= 1'b0;
            end
        end
    end
end

endmodule

// =====================================
// Pin filter and rising edge
module hdse_pin_filt (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Pin and its rising edge
    input wire pin,
    output wire rise
);

reg [2:0] sync_r;
reg filt_r;
reg prev_r;

always @(posedge sys_clk) begin
    if (rst) begin
        sync_r <= 3'b000;
        filt_r <= 1'b0;
        prev_r <= 1'b0;
    end else begin
        sync_r <= {sync_r[1:0], pin};
        if (sync_r[1] == sync_r[2])
            filt_r <= sync_r[2];
        prev_r <= filt_r;
    end
end

assign rise = filt_r & ~prev_r;

endmodule

// =====================================
// Saturating adder for one channel
module hdse_sat_add #(
    parameter W = 10
) (
    // Channel and signed level
    input wire [W-1:0] chan,
    input wire [8:0] lvl,
    // Sum clipped to the channel range
    output wire [W-1:0] sum_sat
);

wire [W+1:0] sum = {2'b00, chan} + {{(W-7){lvl[8]}}, lvl};

assign sum_sat = sum[W+1] ? {W{1'b0}} : (sum[W] ? {W{1'b1}} : sum[W-1:0]);

endmodule

/* File: testbench/hdse_engine_monitor.sv */
`timescale 1ns/1ps
module hdse_engine_monitor (
    // Clock and reset
    input sys_clk,
    input rst,
    // Bus
    input [7:0] avs_address,
    input avs_read,
    input avs_write,
    input [31:0] avs_writedata,
    input [31:0] avs_readdata,
    input avs_waitrequest,
    // Data and pins
    input [9:0] hd_b_in,
    input [9:0] hd_r_in,
    input [9:0] hd_b_out,
    input [9:0] hd_r_out,
    input composite_hsync_pin,
    input vertical_sync_pin
);
    reg en_r;
    wire req = avs_read | avs_write;
    wire done = req & ~avs_waitrequest;
    always @(posedge sys_clk) begin
        if (rst) begin
            en_r <= 1'b0;
        end else if (done && avs_write && avs_address == 8'hDC) begin
            en_r <= avs_writedata[0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // =====================================
    // Checks
    property p_wait;
        req && !$past(req) |-> avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("no wait cycle");
    property p_ans;
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("late answer");
    property p_idle;
        !req |-> !avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("wait when idle");
    property p_wo;
        done && avs_read && avs_address[7:2] == 6'h34 |-> avs_readdata == 32'h0;
    endproperty
    a_wo: assert property (p_wo) else $error("port read not zero");
    property p_rst;
        $past(rst) |-> !composite_hsync_pin && !vertical_sync_pin && hd_b_out == 10'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_off;
        !en_r && !$past(en_r) && !$past(en_r, 2) |-> !composite_hsync_pin && !vertical_sync_pin;
    endproperty
    a_off: assert property (p_off) else $error("sync while off");
    property p_pass;
        !en_r && !$past(en_r) && !$past(en_r, 2) && !$past(rst) |-> hd_r_out == $past(hd_r_in);
    endproperty
    a_pass: assert property (p_pass) else $error("level while off");
    property p_chan;
        hd_b_out != $past(hd_b_in) && !$past(rst) |-> hd_r_out != $past(hd_r_in);
    endproperty
    a_chan: assert property (p_chan) else $error("channels split");
endmodule
bind hdse_engine hdse_engine_monitor u_mon (.*);

/* File: testbench/hdse_sync_src.sv */
`timescale 1ns/1ps
module hdse_sync_src (
    // Clock and reset
    input sys_clk,
    input rst,
    // Reference pins
    output hsync_ref,
    output vsync_ref
);
    // =====================================
    // Lines of 64 pixels, frames of 4 lines
    reg [5:0] pix_r;
    reg [1:0] line_r;
    always @(posedge sys_clk) begin
        if (rst) begin
            pix_r <= 6'h00;
            line_r <= 2'h0;
        end else begin
            pix_r <= pix_r + 6'h01;
            if (pix_r == 6'h3F) begin
                line_r <= line_r + 2'h1;
            end
        end
    end
    assign hsync_ref = pix_r < 6'h04;
    assign vsync_ref = line_r == 2'h0 && pix_r[5];
endmodule

/* File: testbench/tb_hdse_engine.sv */
`timescale 1ns/1ps
module tb_hdse_engine;
    reg sys_clk, rst, avs_read, avs_write;
    reg [7:0] avs_address;
    reg [31:0] avs_writedata, q;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, hsync_ref, vsync_ref, composite_hsync_pin, vertical_sync_pin;
    reg [9:0] hd_g_in, hd_b_in, hd_r_in;
    wire [9:0] hd_g_out, hd_b_out, hd_r_out;
    integer n_mismatch = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer len, i;
    hdse_engine dut (.*);
    hdse_sync_src u_src (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    // =====================================
    // Tasks
    task test_done;
        begin
            if (n_mismatch == 0 && comparisons > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_read <= !w;
            avs_write <= w;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task put(input [7:0] a, input [63:0] b, input integer n);
        begin
            bus(1'b1, a, 32'h100);
            for (i = 0; i < n; i = i + 1) begin
                bus(1'b1, a, (i < 8) ? {24'h0, b[8*i +: 8]} : 32'h0);
            end
        end
    endtask
    task run(input [9:0] v);
        begin
            len = 0;
            while (hd_g_out !== v && len < 2000) begin
                @(posedge sys_clk);
                len = len + 1;
            end
            if (len >= 2000) begin
                n_mismatch = n_mismatch + 1;
                test_done;
            end
            q = {hd_b_out, composite_hsync_pin, vertical_sync_pin};
            len = 0;
            while (hd_g_out === v) begin
                @(posedge sys_clk);
                len = len + 1;
            end
        end
    endtask
    // =====================================
    // Main sequence
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        hd_g_in = 10'h064;
        hd_b_in = 10'h064;
        hd_r_in = 10'h064;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 8'hDC, 32'h0);
        chk("ctrl", 32'h0, q);
        bus(1'b0, 8'hE0, 32'h0);
        chk("status", 32'h0, q);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        put(8'hD0, 64'h1001, 30);
        put(8'hD1, 64'h01, 4);
        put(8'hD2, 64'h90020003, 8);
        put(8'hD3, 64'h02F40100, 4);
        bus(1'b0, 8'hD0, 32'h0);
        chk("port", 32'h0, q);
        bus(1'b1, 8'hD4, 32'h1);
        bus(1'b1, 8'hD6, 32'h3);
        bus(1'b1, 8'hD8, 32'hA);
        bus(1'b1, 8'hDA, 32'h1);
        bus(1'b0, 8'hD4, 32'h0);
        chk("line_state", 32'h1, q);
        bus(1'b0, 8'hD6, 32'h0);
        chk("dur_state", 32'h3, q);
        bus(1'b0, 8'hD8, 32'h0);
        chk("hphase", 32'hA, q);
        bus(1'b0, 8'hDA, 32'h0);
        chk("vphase", 32'h1, q);
        bus(1'b1, 8'hDC, 32'h1);
        run(10'h098);
        chk("len0", 32'h4, len);
        chk("out0", 32'h262, q);
        run(10'h08C);
        chk("len1", 32'h3, len);
        chk("out1", 32'h191, q);
        bus(1'b1, 8'hDC, 32'h0);
        repeat (4) @(posedge sys_clk);
        chk("hs_off", 32'h0, {composite_hsync_pin, vertical_sync_pin});
        test_done;
    end
endmodule
